// ===== design/depc_top.sv
// Local design decision: the APB interface to the registers.
`default_nettype none
module depc_top (
   // Clock and reset
   input  wire  logic        CLK,
   input  wire  logic        RST,
   // APB slave
   input  wire  logic        PSEL,
   input  wire  logic        PENABLE,
   input  wire  logic        PWRITE,
   input  wire  logic [7:0]  PADDR,
   input  wire  logic [31:0] PWDATA,
   output var   logic [31:0] PRDATA,
   output var   logic        PREADY,
   output var   logic        PSLVERR,
   // Main encoder channel
   input  wire  logic        MAIN_ENC_A,
   input  wire  logic        MAIN_ENC_B,
   input  wire  logic        MAIN_STROBE_INPUT_N,
   output var   logic        MAIN_PULSE_OUT,
   output var   logic        MAIN_TOGGLE_OUT,
   // Auxiliary encoder channel
   input  wire  logic        AUX_ENC_A,
   input  wire  logic        AUX_ENC_B,
   input  wire  logic        AUX_STROBE_INPUT_N,
   output var   logic        AUX_PULSE_OUT,
   output var   logic        AUX_TOGGLE_OUT
);
   localparam int CW = depc_pkg::CW;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Block decode: hit flag and field within one channel
   function automatic logic [3:0] fdec(input logic [5:0] idx,
                                       input logic [5:0] base);
      logic [5:0] off;
      off = idx - base;
      fdec = {off < {3'h0, depc_pkg::FIELD_COUNT}, off[2:0]};
   endfunction

   // Quadrature step: {valid, up}
   function automatic logic [1:0] qstep(input logic [1:0] m,
                                        input logic       ap,
                                        input logic       bp,
                                        input logic       a,
                                        input logic       b);
      logic ea;
      logic eb;
      ea = ap ^ a;
      eb = bp ^ b;
      case (m)
         depc_pkg::Q_X1: qstep = {ea & ~b, a};
         depc_pkg::Q_X2: qstep = {ea, a ^ b};
         depc_pkg::Q_X4: qstep = {ea ^ eb, a ^ bp};
         default:        qstep = 2'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB access and decode

   logic              pready_reg;
   logic              pslverr_reg;
   logic [31:0]       prdata_reg;
   logic              acc;
   logic              take;
   logic              wr_take;
   logic              rd_take;
   logic [5:0]        idx;
   logic              ptr_hit;
   logic              bad_addr;
   logic [31:0]       rdata_next;

   assign acc     = PSEL & PENABLE;
   assign take    = acc & pready_reg & ~bad_addr; // Refused access: no effect
   assign wr_take = take & PWRITE;
   assign rd_take = take & ~PWRITE;
   assign idx     = PADDR[7:2];
   assign ptr_hit = idx == depc_pkg::IDX_POINTER;

   ////////////////////////////////////////////////////////////////////////
   // Channel state

   logic [CW-1:0] cnt_reg    [2];
   logic [CW-1:0] cnt_next   [2];
   logic [CW-1:0] snap_reg   [2];
   logic [CW-1:0] snap_next  [2];
   logic [CW-1:0] rld_reg    [2];
   logic [CW-1:0] rld_next   [2];
   logic [7:0]    inset_reg  [2];
   logic [7:0]    inset_next [2];
   logic [7:0]    outset_reg [2];
   logic [7:0]    outset_next[2];
   logic [1:0]    quad_reg   [2];
   logic [1:0]    quad_next  [2];
   logic [1:0]    ptr_reg    [2];
   logic [1:0]    ptr_next   [2];
   logic [1:0]    bt_reg;
   logic [1:0]    bt_next;
   logic [1:0]    ct_reg;
   logic [1:0]    ct_next;
   logic [1:0]    mt_reg;
   logic [1:0]    mt_next;
   logic [1:0]    sign_reg;
   logic [1:0]    sign_next;
   logic [1:0]    dir_reg;
   logic [1:0]    dir_next;
   logic [1:0]    halt_reg;
   logic [1:0]    halt_next;
   logic [1:0]    pulse_reg;
   logic [1:0]    pulse_next;
   logic [1:0]    tog_reg;
   logic [1:0]    tog_next;
   logic [1:0]    a_m_reg;
   logic [1:0]    a_s_reg;
   logic [1:0]    a_p_reg;
   logic [1:0]    b_m_reg;
   logic [1:0]    b_s_reg;
   logic [1:0]    b_p_reg;
   logic [1:0]    st_m_reg;
   logic [1:0]    st_s_reg;
   logic [7:0]    status   [2];
   logic [3:0]    dec      [2];
   logic [1:0]    chit;

   logic [1:0]    pin_a;
   logic [1:0]    pin_b;
   logic [1:0]    pin_st;

   assign pin_a  = {AUX_ENC_A, MAIN_ENC_A};
   assign pin_b  = {AUX_ENC_B, MAIN_ENC_B};
   assign pin_st = {AUX_STROBE_INPUT_N, MAIN_STROBE_INPUT_N};

   assign dec[0] = fdec(idx, depc_pkg::IDX_MAIN_STATUS);
   assign dec[1] = fdec(idx, depc_pkg::IDX_AUX_STATUS);
   assign chit   = {dec[1][3], dec[0][3]};

   assign bad_addr = (PADDR[1:0] != 2'h0) | ~(|chit | ptr_hit);

   ////////////////////////////////////////////////////////////////////////
   // Per-channel counting and command logic

   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [2:0]    fld;
      logic          wsel;
      logic          wcmd;
      logic [7:0]    cmd;
      logic          master;
      logic          cmd_clr;
      logic          cmd_load;
      logic          cmd_snap;
      logic          st_low;
      logic          st_load;
      logic          st_snap;
      logic          cnt_cmd;
      logic [1:0]    q;
      logic          ra;
      logic          rb;
      logic          src_v;
      logic          src_up;
      logic          man_inc;
      logic          man_dec;
      logic          step;
      logic          up;
      logic [CW-1:0] cnt_step;
      logic          carry;
      logic          borrow;
      logic          match;
      logic          ext_c;
      logic          ext_b;
      logic          divn;
      logic          norec;
      logic [1:0]    sel;

      assign fld  = dec[c][2:0];
      assign wsel = wr_take & chit[c];
      assign wcmd = wsel & (fld == depc_pkg::F_COMMAND);
      // Top two bits only address the register inside the counter
      assign cmd  = wcmd ? {2'h0, PWDATA[5:0]} : 8'h00;

      assign master   = cmd[depc_pkg::CMD_MASTER];
      assign cmd_clr  = cmd[depc_pkg::CMD_CLEAR];
      assign cmd_load = cmd[depc_pkg::CMD_LOAD];
      assign cmd_snap = cmd[depc_pkg::CMD_SNAP];

      // Strobe is a level: held low keeps loading or snapshotting
      assign st_low  = ~st_s_reg[c];
      assign st_snap = st_low & inset_reg[c][depc_pkg::IN_STROBE_SNAP];
      assign st_load = st_low & ~inset_reg[c][depc_pkg::IN_STROBE_SNAP];
      assign cnt_cmd = master | cmd_clr | cmd_load | st_load;

      // Count sources
      assign q  = qstep(quad_reg[c], a_p_reg[c], b_p_reg[c],
                        a_s_reg[c], b_s_reg[c]);
      assign ra = a_s_reg[c] & ~a_p_reg[c];
      assign rb = b_s_reg[c] & ~b_p_reg[c];
      assign src_v = (quad_reg[c] != depc_pkg::Q_OFF) ? q[1] :
                     inset_reg[c][depc_pkg::IN_DIR_MODE] ? ra : ra ^ rb;
      assign src_up = (quad_reg[c] != depc_pkg::Q_OFF) ? q[0] :
                      inset_reg[c][depc_pkg::IN_DIR_MODE] ? ~b_s_reg[c] :
                      ra;
      assign man_inc = wsel & (fld == depc_pkg::F_INPUT)
                       & PWDATA[depc_pkg::IN_INC];
      assign man_dec = wsel & (fld == depc_pkg::F_INPUT)
                       & PWDATA[depc_pkg::IN_DEC];
      assign step = ~cnt_cmd & ((man_inc ^ man_dec) |
                    (src_v & inset_reg[c][depc_pkg::IN_ENABLE]
                     & ~halt_reg[c]));
      assign up   = (man_inc ^ man_dec) ? man_inc : src_up;

      assign cnt_step = up ? cnt_reg[c] + 24'h000001
                           : cnt_reg[c] - 24'h000001;
      assign carry  = step & up & (cnt_reg[c] == depc_pkg::COUNT_MAX);
      assign borrow = step & ~up & (cnt_reg[c] == '0);
      assign match  = step & (cnt_step == rld_reg[c]);

      assign divn  = outset_reg[c][depc_pkg::OUT_DIVN];
      assign norec = outset_reg[c][depc_pkg::OUT_NORECYCLE];
      // Non-recycle mode keeps carry and borrow off the pins, except through the SEL_TOGGLES flags
      assign ext_c = carry & ~norec;
      assign ext_b = borrow & ~norec;

      // Counter: clear then load, so bits 2 and 3 together give reload
      assign cnt_next[c] =
         master               ? '0 :
         cmd_load             ? rld_reg[c] :
         cmd_clr              ? '0 :
         st_load              ? rld_reg[c] :
         (step & divn & (carry | borrow)) ? rld_reg[c] :
         step                 ? cnt_step : cnt_reg[c];

      assign halt_next[c] = cnt_cmd ? 1'b0 :
                            halt_reg[c] | (norec & (carry | borrow));

      // Snapshot taken from the counter before this cycle's changes
      assign snap_next[c] = (cmd_snap | st_snap) ? cnt_reg[c]
                                                 : snap_reg[c];

      assign rld_next[c] =
         master ? depc_pkg::RELOAD_RST :
         (wsel & (fld == depc_pkg::F_RELOAD)) ? PWDATA[CW-1:0] :
         rld_reg[c];

      assign inset_next[c] = master ? 8'h00 :
         (wsel & (fld == depc_pkg::F_INPUT)) ? PWDATA[7:0] : inset_reg[c];
      assign outset_next[c] = master ? 8'h00 :
         (wsel & (fld == depc_pkg::F_OUTPUT)) ? PWDATA[7:0] : outset_reg[c];
      assign quad_next[c] = master ? 2'h0 :
         (wsel & (fld == depc_pkg::F_QUAD)) ? PWDATA[1:0] : quad_reg[c];

      // Byte pointer: steps per reload write or snapshot read
      assign ptr_next[c] =
         (master | cmd[depc_pkg::CMD_PTR_CLR]) ? 2'h0 :
         ((wsel & (fld == depc_pkg::F_RELOAD)) |
          (rd_take & chit[c] & (fld == depc_pkg::F_SNAPSHOT))) ?
            ((ptr_reg[c] == depc_pkg::PTR_LAST) ? 2'h0
                                                : ptr_reg[c] + 2'h1) :
         ptr_reg[c];

      // Toggles: a match clear and a match in one cycle leave the match flag set
      assign bt_next[c] = ~(master | cmd_clr) & bt_reg[c] ^ borrow;
      assign ct_next[c] = ~(master | cmd_clr) & ct_reg[c] ^ carry;
      assign mt_next[c] = ~(master | cmd[depc_pkg::CMD_MATCH_CLR])
                          & mt_reg[c] ^ match;
      assign sign_next[c] = (master | cmd_clr) ? 1'b1 :
                            carry ? 1'b1 : borrow ? 1'b0 : sign_reg[c];
      assign dir_next[c]  = step ? up : dir_reg[c];

      assign status[c] = {depc_pkg::STATUS_ONES,
         (quad_reg[c] == depc_pkg::Q_OFF) ? 1'b1 : dir_reg[c],
         sign_reg[c], mt_reg[c], ct_reg[c], bt_reg[c]};

      // Pin selection
      assign sel = outset_reg[c][depc_pkg::OUT_SEL_LO +: 2];
      always_comb begin
         case (sel)
            depc_pkg::SEL_EVENT_N: begin
               pulse_next[c] = ~ext_c;
               tog_next[c]   = ~ext_b;
            end
            depc_pkg::SEL_TOGGLES: begin
               pulse_next[c] = ct_next[c];
               tog_next[c]   = bt_next[c];
            end
            depc_pkg::SEL_EVENT: begin
               pulse_next[c] = ext_c;
               tog_next[c]   = ext_b;
            end
            depc_pkg::SEL_MATCH: begin
               pulse_next[c] = ~match;
               tog_next[c]   = mt_next[c];
            end
            default: begin
               pulse_next[c] = 1'b1;
               tog_next[c]   = 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data; write-only registers read as zero

   always_comb begin
      rdata_next = 32'h00000000;
      if (ptr_hit) begin
         rdata_next = {28'h0000000, ptr_reg[1], ptr_reg[0]};
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (chit[c] && dec[c][2:0] == depc_pkg::F_STATUS) begin
               rdata_next = {24'h000000, status[c]};
            end
            if (chit[c] && dec[c][2:0] == depc_pkg::F_SNAPSHOT) begin
               rdata_next = {8'h00, snap_reg[c]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // One wait state; read data caught in the first access cycle
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= acc & ~pready_reg;
         pslverr_reg <= acc & ~pready_reg & bad_addr;
         prdata_reg  <= (acc & ~pready_reg & ~PWRITE & ~bad_addr) ? rdata_next
                                                      : 32'h00000000;
      end
   end

   // Pins pass two flops before use
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         a_m_reg  <= 2'h0;
         a_s_reg  <= 2'h0;
         a_p_reg  <= 2'h0;
         b_m_reg  <= 2'h0;
         b_s_reg  <= 2'h0;
         b_p_reg  <= 2'h0;
         st_m_reg <= 2'h3;
         st_s_reg <= 2'h3;
      end else begin
         a_m_reg  <= pin_a;
         a_s_reg  <= a_m_reg;
         a_p_reg  <= a_s_reg;
         b_m_reg  <= pin_b;
         b_s_reg  <= b_m_reg;
         b_p_reg  <= b_s_reg;
         st_m_reg <= pin_st;
         st_s_reg <= st_m_reg;
      end
   end

   // Reset state matches a master reset, except snap_reg, which a master reset keeps
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         for (int c = 0; c < 2; c++) begin
            cnt_reg[c]    <= '0;
            snap_reg[c]   <= '0;
            rld_reg[c]    <= depc_pkg::RELOAD_RST;
            inset_reg[c]  <= 8'h00;
            outset_reg[c] <= 8'h00;
            quad_reg[c]   <= 2'h0;
            ptr_reg[c]    <= 2'h0;
         end
      end else begin
         for (int c = 0; c < 2; c++) begin
            cnt_reg[c]    <= cnt_next[c];
            snap_reg[c]   <= snap_next[c];
            rld_reg[c]    <= rld_next[c];
            inset_reg[c]  <= inset_next[c];
            outset_reg[c] <= outset_next[c];
            quad_reg[c]   <= quad_next[c];
            ptr_reg[c]    <= ptr_next[c];
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         bt_reg    <= 2'h0;
         ct_reg    <= 2'h0;
         mt_reg    <= 2'h0;
         sign_reg  <= 2'h3;
         dir_reg   <= 2'h3;
         halt_reg  <= 2'h0;
         pulse_reg <= 2'h3;
         tog_reg   <= 2'h3;
      end else begin
         bt_reg    <= bt_next;
         ct_reg    <= ct_next;
         mt_reg    <= mt_next;
         sign_reg  <= sign_next;
         dir_reg   <= dir_next;
         halt_reg  <= halt_next;
         pulse_reg <= pulse_next;
         tog_reg   <= tog_next;
      end
   end

   assign PRDATA          = prdata_reg;
   assign PREADY          = pready_reg;
   assign PSLVERR         = pslverr_reg;
   assign MAIN_PULSE_OUT  = pulse_reg[0];
   assign MAIN_TOGGLE_OUT = tog_reg[0];
   assign AUX_PULSE_OUT   = pulse_reg[1];
   assign AUX_TOGGLE_OUT  = tog_reg[1];

endmodule
`default_nettype wire

// ===== design/depc_pkg.sv
`default_nettype none
package depc_pkg;
   localparam int CW = 24;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_MAIN_STATUS   = 6'h14;
   localparam logic [5:0] IDX_MAIN_SNAPSHOT = 6'h15;
   localparam logic [5:0] IDX_MAIN_RELOAD   = 6'h16;
   localparam logic [5:0] IDX_MAIN_COMMAND  = 6'h17;
   localparam logic [5:0] IDX_AUX_STATUS    = 6'h1E;
   localparam logic [5:0] IDX_AUX_SNAPSHOT  = 6'h1F;
   localparam logic [5:0] IDX_AUX_RELOAD    = 6'h20;
   localparam logic [5:0] IDX_AUX_COMMAND   = 6'h21;
   localparam logic [5:0] IDX_POINTER       = 6'h27;
   // Field position within a channel's block of seven registers
   typedef enum logic [2:0] {
      F_STATUS   = 3'h0,
      F_SNAPSHOT = 3'h1,
      F_RELOAD   = 3'h2,
      F_COMMAND  = 3'h3,
      F_INPUT    = 3'h4,
      F_OUTPUT   = 3'h5,
      F_QUAD     = 3'h6
   } depc_field_type;
   localparam logic [2:0] FIELD_COUNT = 3'h7;
   // Command bits
   localparam int CMD_PTR_CLR   = 0;
   localparam int CMD_SNAP      = 1;
   localparam int CMD_CLEAR     = 2;
   localparam int CMD_LOAD      = 3;
   localparam int CMD_MATCH_CLR = 4;
   localparam int CMD_MASTER    = 5;
   // Input setup bits
   localparam int IN_DIR_MODE   = 0;
   localparam int IN_INC        = 1;
   localparam int IN_DEC        = 2;
   localparam int IN_ENABLE     = 3;
   localparam int IN_STROBE_SNAP = 5;
   // Output setup bits
   localparam int OUT_NORECYCLE = 1;
   localparam int OUT_DIVN      = 2;
   localparam int OUT_SEL_LO    = 4;
   typedef enum logic [1:0] {
      SEL_EVENT_N  = 2'h0,
      SEL_TOGGLES  = 2'h1,
      SEL_EVENT    = 2'h2,
      SEL_MATCH    = 2'h3
   } depc_outsel_type;
   // Quadrature modes
   typedef enum logic [1:0] {
      Q_OFF = 2'h0,
      Q_X1  = 2'h1,
      Q_X2  = 2'h2,
      Q_X4  = 2'h3
   } depc_quad_type;
   // Reset values, count maximum, last pointer value and status ones
   localparam logic [CW-1:0] RELOAD_RST = 24'hFFFFFF;
   localparam logic [CW-1:0] COUNT_MAX  = 24'hFFFFFF;
   localparam logic [2:0]    STATUS_ONES = 3'h7;
   localparam logic [1:0]    PTR_LAST   = 2'h2;
endpackage
`default_nettype wire

// ===== bench/depc_props.sv
`default_nettype none
module depc_props (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        RST,
   // APB
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // Main channel pins
   input wire logic        MAIN_PULSE_OUT,
   input wire logic        MAIN_TOGGLE_OUT
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   wire       acc   = PSEL && PENABLE;
   wire       rd_ok = PREADY && !PWRITE && !PSLVERR;
   wire [5:0] idx   = PADDR[7:2];
   ////////////////////////////////////////////////////////////
   sequence acc_open;
      $rose(acc);
   endsequence
   sequence one_wait;
      !PREADY ##1 PREADY;
   endsequence
   sequence master_cmd;
      PREADY && PWRITE && !PSLVERR && PWDATA[5] &&
      idx == depc_pkg::IDX_MAIN_COMMAND;
   endsequence
   ////////////////////////////////////////////////////////////
   ready_wait_a: assert property (acc_open |-> one_wait)
      else $error("PREADY not after exactly one wait");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("PREADY held longer than one cycle");
   err_align_a: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
      else $error("misaligned access not refused");
   idle_rdata_a: assert property (!(PREADY && !PWRITE) |-> PRDATA == 32'h0)
      else $error("PRDATA nonzero outside read answer");
   err_data_a: assert property (PSLVERR |-> PRDATA == 32'h0)
      else $error("refused access returned data");
   wo_read_a: assert property (
      rd_ok && idx == depc_pkg::IDX_MAIN_COMMAND |-> PRDATA == 32'h0)
      else $error("command word read back nonzero");
   snap_width_a: assert property (
      rd_ok && idx == depc_pkg::IDX_MAIN_SNAPSHOT |-> PRDATA[31:24] == 8'h0)
      else $error("snapshot wider than 24 bits");
   status_ones_a: assert property (
      rd_ok && (idx == depc_pkg::IDX_MAIN_STATUS ||
      idx == depc_pkg::IDX_AUX_STATUS) |-> PRDATA[31:5] == 27'h7)
      else $error("status upper bits wrong");
   master_pins_a: assert property (
      master_cmd |-> ##3 (MAIN_PULSE_OUT && MAIN_TOGGLE_OUT) [*4])
      else $error("pins not idle after master reset");
endmodule
bind depc_top depc_props i_depc_props (.CLK, .RST, .PSEL, .PENABLE,
   .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
   .MAIN_PULSE_OUT, .MAIN_TOGGLE_OUT);
`default_nettype wire

// ===== bench/depc_enc_model.sv
`default_nettype none
module depc_enc_model (
   // Clock
   input  wire logic clk,
   // Encoder and strobe wiring
   output var  logic enc_a,
   output var  logic enc_b,
   output var  logic strobe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_reg = 2'h0;
   assign enc_a = (phase_reg == 2'h1) || (phase_reg == 2'h2);
   assign enc_b = phase_reg[1];
   // Idle high: a feedback channel must never see it low
   initial strobe_n = 1'h1;
   // Four clocks per edge, above the three-clock minimum spacing
   task automatic step(input logic up, input int n);
      repeat (n) begin
         @(posedge clk);
         phase_reg <= up ? phase_reg + 2'h1 : phase_reg - 2'h1;
         repeat (3) @(posedge clk);
      end
   endtask
   task automatic strobe(input int n);
      @(posedge clk);
      strobe_n <= 1'h0;
      repeat (n) @(posedge clk);
      strobe_n <= 1'h1;
      repeat (4) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== bench/depc_top_tb.sv
`default_nettype none
module depc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] MSTS = depc_pkg::IDX_MAIN_STATUS;
   localparam logic [5:0] MSNP = depc_pkg::IDX_MAIN_SNAPSHOT;
   localparam logic [5:0] MRLD = depc_pkg::IDX_MAIN_RELOAD;
   localparam logic [5:0] MCMD = depc_pkg::IDX_MAIN_COMMAND;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, d;
   logic        m_a, m_b, m_s_n, m_p, m_t, x_a, x_b, x_s_n, x_p, x_t;
   logic [1:0]  lo         = 2'h0;
   int          num_errors = 0;
   int          n_tests    = 0;
   int          cycles     = 0;
   depc_top i_depc_top (.CLK(clk), .RST(rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MAIN_ENC_A(m_a), .MAIN_ENC_B(m_b), .MAIN_STROBE_INPUT_N(m_s_n),
      .MAIN_PULSE_OUT(m_p), .MAIN_TOGGLE_OUT(m_t), .AUX_ENC_A(x_a),
      .AUX_ENC_B(x_b), .AUX_STROBE_INPUT_N(x_s_n), .AUX_PULSE_OUT(x_p),
      .AUX_TOGGLE_OUT(x_t));
   depc_enc_model i_depc_enc_model (.clk(clk), .enc_a(m_a), .enc_b(m_b),
      .strobe_n(m_s_n));
   depc_enc_model i_depc_enc_model_aux (.clk(clk), .enc_a(x_a),
      .enc_b(x_b), .strobe_n(x_s_n));
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("Checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      n_tests++;
      if (g !== x) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [5:0] i,
                      input logic [31:0] v);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= {i, lo};
      pwdata <= v;
      @(posedge clk);
      penable <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      d = prdata;
      e = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [5:0] i, input logic [31:0] v);
      apb(1'h1, i, v);
   endtask
   task automatic rd(input string nm, input logic [5:0] i,
                     input logic [31:0] x);
      apb(1'h0, i, 32'h0);
      chk(nm, x, d);
      chk("slverr", 32'h0, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd("main status", MSTS, 32'hF8);
      rd("aux status", depc_pkg::IDX_AUX_STATUS, 32'hF8);
      rd("main snapshot", MSNP, 32'h0);
      chk("aux pins", 32'h3, {30'h0, x_p, x_t});
   endtask
   task automatic t_load;
      wr(MRLD, 32'h123456);
      wr(MCMD, 32'h08);
      wr(MCMD, 32'h02);
      rd("loaded count", MSNP, 32'h123456);
      rd("command reads 0", MCMD, 32'h0);
      wr(depc_pkg::IDX_AUX_COMMAND, 32'h02);
      rd("aux untouched", depc_pkg::IDX_AUX_SNAPSHOT, 32'h0);
   endtask
   task automatic t_combine;
      wr(MRLD, 32'h654321);
      rd("pointer before", 6'h27, 32'h5);
      wr(MCMD, 32'h01);
      rd("pointer", 6'h27, 32'h4);
      wr(MCMD, 32'h0C);
      wr(MCMD, 32'h02);
      rd("combined", MSNP, 32'h654321);
      wr(MCMD, 32'h04);
      wr(MCMD, 32'h02);
      rd("cleared", MSNP, 32'h0);
   endtask
   task automatic t_count;
      wr(MRLD, 32'h2);
      wr(6'h1A, 32'h3);
      wr(6'h18, 32'h8);
      i_depc_enc_model.step(1'h1, 2);
      rd("match", MSTS, 32'hFC);
      wr(MCMD, 32'h10);
      rd("match cleared", MSTS, 32'hF8);
      i_depc_enc_model.step(1'h0, 3);
      rd("borrow", MSTS, 32'hE1);
      wr(MCMD, 32'h02);
      rd("wrapped", MSNP, 32'hFFFFFF);
      i_depc_enc_model.step(1'h1, 1);
      rd("carry", MSTS, 32'hFB);
   endtask
   task automatic t_modes;
      logic [31:0] x [4] = '{32'h0, 32'h1, 32'h2, 32'h4};
      for (int m = 0; m < 4; m++) begin
         wr(MCMD, 32'h04);
         wr(6'h1A, 32'(m));
         i_depc_enc_model.step(1'h1, 4);
         wr(MCMD, 32'h02);
         rd("mode count", MSNP, x[m]);
      end
   endtask
   task automatic t_strobe;
      wr(6'h18, 32'h28);
      i_depc_enc_model.strobe(3);
      rd("strobe snapshot", MSNP, 32'h4);
      wr(6'h18, 32'h08);
      i_depc_enc_model.strobe(3);
      wr(MCMD, 32'h02);
      rd("strobe load", MSNP, 32'h2);
   endtask
   task automatic t_master;
      wr(MCMD, 32'h20);
      rd("master status", MSTS, 32'hF8);
      wr(MCMD, 32'h08);
      wr(MCMD, 32'h02);
      rd("master reload", MSNP, 32'hFFFFFF);
      chk("toggle pin", 32'h1, {31'h0, m_t});
      wr(6'h19, 32'h30);
      @(posedge clk);
      chk("match pin", 32'h0, {31'h0, m_t});
      chk("pulse pin", 32'h1, {31'h0, m_p});
   endtask
   task automatic t_divn;
      wr(MRLD, 32'h5);
      wr(6'h19, 32'h04);
      wr(6'h1A, 32'h3);
      wr(6'h18, 32'h8);
      i_depc_enc_model.step(1'h1, 1);
      wr(MCMD, 32'h02);
      rd("divide reload", MSNP, 32'h5);
      wr(6'h18, 32'h0A);
      wr(MCMD, 32'h02);
      rd("manual step", MSNP, 32'h6);
      apb(1'h0, 6'h3F, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, d);
      lo = 2'h2;
      apb(1'h0, MSTS, 32'h0);
      lo = 2'h0;
      chk("misaligned err", 32'h1, {31'h0, e});
      chk("misaligned data", 32'h0, d);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      rst     = 1'h1;
      psel    = 1'h0;
      penable = 1'h0;
      pwrite  = 1'h0;
      paddr   = 8'h0;
      pwdata  = 32'h0;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_reset();
      t_load();
      t_combine();
      t_count();
      t_modes();
      t_strobe();
      t_master();
      t_divn();
      report_and_stop();
   end
endmodule
`default_nettype wire
